// [rtl/nvac_regs.svh]
// register offsets, field positions, reset values and timing counts of the nonvolatile access controller
// assumes: included by the controller, the checker and the bench by bare name
`ifndef NVAC_REGS_SVH
`define NVAC_REGS_SVH

`define NVAC_OFS_ADDR_LOW 6'h21
`define NVAC_OFS_ADDR_HIGH 6'h22
`define NVAC_OFS_DATA 6'h20
`define NVAC_OFS_CONTROL 6'h1F

`define NVAC_BIT_READ 0
`define NVAC_BIT_WRITE 1
`define NVAC_BIT_ARM 2
`define NVAC_BIT_IRQ_EN 3
`define NVAC_HIGH_BITS 3

`define NVAC_ADDR_RESET 11'h000
`define NVAC_DATA_RESET 8'h00

`define NVAC_ARM_CYCLES 4
`define NVAC_WRITE_STALL 2
`define NVAC_READ_STALL 4
`define NVAC_WRITE_OSC_CYCLES 27072

`endif

// [rtl/nvac_pkg.sv]
// types shared by the nonvolatile access controller
// assumes: nothing beyond the compiler
package nvac_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } nvac_io_req_type;

    typedef struct packed {
        logic req;
        logic [9:0] addr;
        logic [7:0] wdata;
    } nvac_mem_wr_type;

    typedef enum logic [1:0] {
        NVAC_IDLE = 2'b01,
        NVAC_BUSY = 2'b10
    } nvac_write_state_type;
endpackage : nvac_pkg

// [rtl/nvac_countdown.sv]
// down counter loaded with a count, pulses done as it expires
// assumes: one clock, synchronous reset
`timescale 1ns/100ps
`default_nettype none
module nvac_countdown #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // control
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    input wire logic tick,
    // status
    output logic running,
    output logic done
);
    logic [WIDTH-1:0] remain;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            remain <= '0;
            done <= 1'b0;
        end else if (load) begin
            remain <= count;
            done <= 1'b0;
        end else if (tick && remain != '0) begin
            remain <= remain - 1'b1;
            done <= (remain == {{(WIDTH-1){1'b0}}, 1'b1});
        end else begin
            done <= 1'b0;
        end
    end

    assign running = (remain != '0);
endmodule : nvac_countdown
`default_nettype wire

// [rtl/nvac_cell_array.sv]
// byte storage of the data memory, flip-flops indexed by address
// assumes: writes arrive as a single request pulse; read is combinational
`timescale 1ns/100ps
`default_nettype none
module nvac_cell_array
    import nvac_pkg::*;
#(
    parameter int DEPTH = 1024,
    parameter int AW = 10
) (
    // clock
    input wire logic core_clk,
    // write port
    input wire nvac_mem_wr_type wr,
    // read port
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    // contents are nonvolatile: no reset, so a reset cannot disturb stored bytes
    logic [7:0] cells [DEPTH];

    always_ff @(posedge core_clk) begin
        if (wr.req) begin
            cells[wr.addr] <= wr.wdata;
        end
    end

    assign rd_data = cells[rd_addr];
endmodule : nvac_cell_array
`default_nettype wire

// [rtl/nvac_ctrl.sv]
// nonvolatile byte access controller: address, data and control registers in io space
// assumes: cpu io bus with one-cycle write and read strobes; oscillator tick from the calibrated rc
`timescale 1ns/100ps
`include "nvac_regs.svh"
`default_nettype none
module nvac_ctrl
    import nvac_pkg::*;
#(
    parameter int WRITE_OSC_CYCLES = `NVAC_WRITE_OSC_CYCLES,
    parameter int DEPTH = 1024,
    parameter int AW = 10
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // cpu io bus
    input wire nvac_io_req_type io_req,
    output logic [7:0] io_rdata,
    // cpu side status
    input wire logic global_irq_enable,
    input wire logic self_program_active,
    output logic cpu_stall,
    output logic ready_irq,
    // timing reference
    input wire logic osc_tick
);
    localparam int CW = $clog2(WRITE_OSC_CYCLES + 1);

    logic [10:0] nv_byte_address;
    logic [7:0] nv_data_byte;
    logic ready_irq_enable;
    logic master_write_arm;
    logic write_strobe;
    logic read_strobe;
    logic [2:0] arm_count;
    logic [2:0] stall_count;
    nvac_write_state_type state;
    nvac_mem_wr_type mem_wr;
    logic [7:0] mem_rdata;
    logic timer_done;

    logic wr_low;
    logic wr_high;
    logic wr_data;
    logic wr_ctrl;
    logic start_write;
    logic start_read;

    assign wr_low = io_req.wr && io_req.addr == `NVAC_OFS_ADDR_LOW;
    assign wr_high = io_req.wr && io_req.addr == `NVAC_OFS_ADDR_HIGH;
    assign wr_data = io_req.wr && io_req.addr == `NVAC_OFS_DATA;
    assign wr_ctrl = io_req.wr && io_req.addr == `NVAC_OFS_CONTROL;

    // strobe accepted only while armed, idle and flash not being programmed
    assign start_write = wr_ctrl && io_req.wdata[`NVAC_BIT_WRITE] && master_write_arm
        && state == NVAC_IDLE && !self_program_active;
    // reads blocked while a write is in progress
    assign start_read = wr_ctrl && io_req.wdata[`NVAC_BIT_READ] && !write_strobe && !start_write;

    // address register: frozen during a write, undefined value replaced by zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            nv_byte_address <= `NVAC_ADDR_RESET;
        end else if (!write_strobe) begin
            if (wr_low) begin
                nv_byte_address[7:0] <= io_req.wdata;
            end
            if (wr_high) begin
                nv_byte_address[10:8] <= io_req.wdata[`NVAC_HIGH_BITS-1:0];
            end
        end
    end

    // data register: cpu writes it, a read loads it from the array
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            nv_data_byte <= `NVAC_DATA_RESET;
        end else if (start_read) begin
            nv_data_byte <= mem_rdata;
        end else if (wr_data) begin
            nv_data_byte <= io_req.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ready_irq_enable <= 1'b0;
        end else if (wr_ctrl) begin
            ready_irq_enable <= io_req.wdata[`NVAC_BIT_IRQ_EN];
        end
    end

    // arm bit times out four cycles after being set
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            master_write_arm <= 1'b0;
            arm_count <= 3'h0;
        end else if (wr_ctrl && io_req.wdata[`NVAC_BIT_ARM] && !master_write_arm) begin
            master_write_arm <= 1'b1;
            arm_count <= 3'(`NVAC_ARM_CYCLES - 1);
        end else if (master_write_arm) begin
            if (arm_count == 3'h0) begin
                master_write_arm <= 1'b0;
            end else begin
                arm_count <= arm_count - 3'h1;
            end
        end
    end

    // write sequence; reset does not abort a write already under way
    always_ff @(posedge core_clk) begin
        if (!rst_n && state == NVAC_IDLE) begin
            state <= NVAC_IDLE;
            write_strobe <= 1'b0;
        end else begin
            unique case (state)
                NVAC_IDLE: begin
                    if (start_write && rst_n) begin
                        state <= NVAC_BUSY;
                        write_strobe <= 1'b1;
                    end
                end
                NVAC_BUSY: begin
                    if (timer_done) begin
                        state <= NVAC_IDLE;
                        write_strobe <= 1'b0;
                    end
                end
                default: begin
                    state <= NVAC_IDLE;
                    write_strobe <= 1'b0;
                end
            endcase
        end
    end

    // latched write request; the byte is committed when the timer expires
    always_ff @(posedge core_clk) begin
        if (start_write && rst_n && state == NVAC_IDLE) begin
            mem_wr.addr <= nv_byte_address[AW-1:0];
            mem_wr.wdata <= nv_data_byte;
        end
        mem_wr.req <= state == NVAC_BUSY && timer_done;
    end

    // read strobe: single cycle, never held, so writing zero has no effect
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            read_strobe <= 1'b0;
        end else begin
            read_strobe <= start_read;
        end
    end

    // cpu stall: two cycles after a write start, four after a read
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stall_count <= 3'h0;
            cpu_stall <= 1'b0;
        end else if (start_write) begin
            stall_count <= 3'(`NVAC_WRITE_STALL - 1);
            cpu_stall <= 1'b1;
        end else if (start_read) begin
            stall_count <= 3'(`NVAC_READ_STALL - 1);
            cpu_stall <= 1'b1;
        end else if (stall_count != 3'h0) begin
            stall_count <= stall_count - 3'h1;
        end else begin
            cpu_stall <= 1'b0;
        end
    end

    // level interrupt while idle and enabled
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ready_irq <= 1'b0;
        end else begin
            ready_irq <= ready_irq_enable && global_irq_enable && !write_strobe && !start_write;
        end
    end

    // read data mux, reserved bits zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            io_rdata <= 8'h00;
        end else if (io_req.rd) begin
            unique case (io_req.addr)
                `NVAC_OFS_ADDR_LOW: io_rdata <= nv_byte_address[7:0];
                `NVAC_OFS_ADDR_HIGH: io_rdata <= {5'h00, nv_byte_address[10:8]};
                `NVAC_OFS_DATA: io_rdata <= nv_data_byte;
                `NVAC_OFS_CONTROL: io_rdata <= {4'h0, ready_irq_enable, master_write_arm,
                    write_strobe, read_strobe};
                default: io_rdata <= 8'h00;
            endcase
        end else begin
            io_rdata <= 8'h00;
        end
    end

    // write duration counted in calibrated oscillator ticks
    // timer is only cleared by a reset while idle, so a write under way keeps counting
    nvac_countdown #(
        .WIDTH(CW)
    ) i_nvac_countdown (
        .core_clk(core_clk),
        .rst_n(rst_n || state != NVAC_IDLE),
        .load(start_write && state == NVAC_IDLE),
        .count(CW'(WRITE_OSC_CYCLES)),
        .tick(osc_tick),
        .running(),
        .done(timer_done)
    );

    nvac_cell_array #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) i_nvac_cell_array (
        .core_clk(core_clk),
        .wr(mem_wr),
        .rd_addr(nv_byte_address[AW-1:0]),
        .rd_data(mem_rdata)
    );
endmodule : nvac_ctrl
`default_nettype wire

// [verification/nvac_checker.sv]
// port checker of nvac_ctrl, bound to every instance
// assumes: the core never issues a request while cpu_stall is high
`timescale 1ns/100ps
`include "nvac_regs.svh"
`default_nettype none
module nvac_checker
    import nvac_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // io bus and cpu lines
    input wire nvac_io_req_type io_req,
    input wire logic [7:0] io_rdata,
    input wire logic global_irq_enable,
    input wire logic self_program_active,
    input wire logic cpu_stall,
    input wire logic ready_irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic ctl;
    logic [2:0] age;
    assign ctl = io_req.wr && io_req.addr == `NVAC_OFS_CONTROL;
    // cycles since the last arm write; saturates so a stale arm never looks fresh
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            age <= 3'h7;
        end else if (ctl && io_req.wdata[2]) begin
            age <= 3'h0;
        end else if (age != 3'h7) begin
            age <= age + 3'h1;
        end
    end
    sequence s_hold2;
        cpu_stall [*2] ##1 !cpu_stall;
    endsequence
    sequence s_hold4;
        cpu_stall [*4] ##1 !cpu_stall;
    endsequence
    chk_stall_length: assert property ($rose(cpu_stall) |-> s_hold2 or s_hold4)
        else $error("stall length wrong");
    chk_stall_cause: assert property ($rose(cpu_stall) |-> $past(ctl) && $past(io_req.wdata[1:0]) != 2'h0)
        else $error("stall without strobe");
    chk_unarmed_ignored: assert property (ctl && io_req.wdata[2:0] == 3'h2 && age >= 3'h4 |=> !cpu_stall)
        else $error("unarmed strobe started a write");
    chk_flash_blocks: assert property (ctl && io_req.wdata[1:0] == 2'h2 && self_program_active |=> !cpu_stall)
        else $error("write during self-programming");
    chk_irq_gated: assert property (!global_irq_enable |=> !ready_irq)
        else $error("interrupt while globally off");
    chk_high_zero: assert property (io_req.rd && io_req.addr == `NVAC_OFS_ADDR_HIGH |=> io_rdata[7:3] == 5'h00)
        else $error("high address bits not zero");
    chk_arm_expired: assert property (io_req.rd && ctl == 1'b0 && io_req.addr == `NVAC_OFS_CONTROL && age >= 3'h4
        |=> !io_rdata[2])
        else $error("arm bit outlived its window");
    chk_rdata_idle: assert property (!io_req.rd |=> io_rdata == 8'h00)
        else $error("read data without a read");
endmodule : nvac_checker
bind nvac_ctrl nvac_checker i_nvac_checker (.core_clk(core_clk), .rst_n(rst_n), .io_req(io_req),
    .io_rdata(io_rdata), .global_irq_enable(global_irq_enable), .self_program_active(self_program_active),
    .cpu_stall(cpu_stall), .ready_irq(ready_irq));
`default_nettype wire

// [verification/nvac_cpu_model.sv]
// cpu core model: one io request per call, honouring the halt
// assumes: the bench calls put; status lines come from the bench
`timescale 1ns/100ps
`default_nettype none
module nvac_cpu_model
    import nvac_pkg::*;
(
    // clock and halt
    input wire logic core_clk,
    input wire logic cpu_stall,
    // io bus
    input wire logic [7:0] io_rdata,
    output var nvac_io_req_type io_req
);
    // set when a halt outlasts the bound; the bench turns it into a mismatch
    logic hung = 1'b0;
    initial io_req = '0;
    // a halted core issues nothing until the halt ends or 20 cycles pass; the read answer stands one cycle only
    task automatic put(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(negedge core_clk);
        while (cpu_stall && n < 20) begin
            n++;
            @(negedge core_clk);
        end
        if (cpu_stall) begin
            hung = 1'b1;
        end
        @(posedge core_clk);
        io_req <= '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(posedge core_clk);
        io_req <= '0;
        @(negedge core_clk);
        q = io_rdata;
    endtask : put
endmodule : nvac_cpu_model
`default_nettype wire

// [verification/nvac_ctrl_test.sv]
// bench of nvac_ctrl: round trips, refused writes, interrupt, reset in mid-write
// assumes: nvac_cpu_model issues the requests; nvac_checker is bound to the design
`timescale 1ns/100ps
`include "nvac_regs.svh"
`default_nettype none
module nvac_ctrl_test;
    localparam int WOC = 8;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic osc_tick = 1'b0;
    logic pend = 1'b0;
    logic gie = 1'b0;
    logic spa = 1'b0;
    nvac_pkg::nvac_io_req_type io_req;
    logic [7:0] io_rdata;
    logic cpu_stall;
    logic ready_irq;
    logic [8:0] exp_q[$];
    logic [7:0] q;
    logic [7:0] seed = 8'h04;
    logic [7:0] keep;
    logic [10:0] a;
    int err_count = 0;
    int checks = 0;
    int tick_count = 0;
    int ticks;
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        osc_tick <= !osc_tick;
        tick_count <= tick_count + osc_tick;
        pend <= io_req.rd;
    end
    nvac_ctrl #(.WRITE_OSC_CYCLES(WOC)) i_nvac_ctrl (.core_clk(core_clk), .rst_n(rst_n), .io_req(io_req),
        .io_rdata(io_rdata), .global_irq_enable(gie), .self_program_active(spa), .cpu_stall(cpu_stall),
        .ready_irq(ready_irq), .osc_tick(osc_tick));
    nvac_cpu_model i_nvac_cpu_model (.core_clk(core_clk), .cpu_stall(cpu_stall), .io_rdata(io_rdata),
        .io_req(io_req));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks++;
        if (seen !== want) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask : check
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next
    task automatic close_out;
        $display("checks %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    // each read leaves a note; c low means only the poller looks at the answer
    task automatic acc(input logic wr, input logic [5:0] ad, input logic [7:0] d, input logic c);
        if (!wr) begin
            exp_q.push_back({c, d});
        end
        i_nvac_cpu_model.put(wr, ad, d, q);
        if (i_nvac_cpu_model.hung) begin
            err_count++;
            close_out();
        end
    endtask : acc
    // gap below zero leaves the arm write out
    task automatic nv_op(input logic rd, input logic [10:0] ad, input logic [7:0] d, input int gap,
        input logic [7:0] ie);
        acc(1'b1, `NVAC_OFS_ADDR_HIGH, {5'h00, ad[10:8]}, 1'b0);
        acc(1'b1, `NVAC_OFS_ADDR_LOW, ad[7:0], 1'b0);
        if (rd) begin
            acc(1'b1, `NVAC_OFS_CONTROL, 8'h01, 1'b0);
            acc(1'b0, `NVAC_OFS_DATA, d, 1'b1);
        end else begin
            acc(1'b1, `NVAC_OFS_DATA, d, 1'b0);
            if (gap >= 0) begin
                acc(1'b1, `NVAC_OFS_CONTROL, 8'h04 | ie, 1'b0);
            end
            repeat (gap) @(posedge core_clk);
            acc(1'b1, `NVAC_OFS_CONTROL, 8'h02 | ie, 1'b0);
        end
    endtask : nv_op
    task automatic wait_idle;
        int n;
        n = 0;
        ticks = tick_count;
        q = 8'hFF;
        while (q[`NVAC_BIT_WRITE] !== 1'b0 && n < 200) begin
            acc(1'b0, `NVAC_OFS_CONTROL, 8'h00, 1'b0);
            n++;
        end
        ticks = tick_count - ticks;
        if (q[`NVAC_BIT_WRITE] !== 1'b0) begin
            err_count++;
            close_out();
        end
        check(q & 8'h05, 8'h00);
    endtask : wait_idle
    always @(negedge core_clk) begin
        if (pend && exp_q.size() > 0) begin
            if (exp_q[0][8]) begin
                check(io_rdata, exp_q[0][7:0]);
            end
            void'(exp_q.pop_front());
        end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        acc(1'b0, `NVAC_OFS_ADDR_LOW, 8'h00, 1'b1);
        acc(1'b1, `NVAC_OFS_ADDR_HIGH, 8'hFF, 1'b0);
        acc(1'b0, `NVAC_OFS_ADDR_HIGH, 8'h07, 1'b1);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr_next(seed);
            a = 11'(i * 1023);
            nv_op(1'b0, a, seed, 0, 8'h00);
            wait_idle();
            check({7'h00, ticks >= WOC - 1 && ticks <= WOC + 4}, 8'h01);
            nv_op(1'b1, {1'b0, a[9:0]}, seed, 0, 8'h00);
        end
        keep = seed;
        $display("round trips done");
        nv_op(1'b0, a, 8'hC3, -1, 8'h00);
        nv_op(1'b1, a, keep, 0, 8'h00);
        nv_op(1'b0, a, 8'hC3, 6, 8'h00);
        nv_op(1'b1, a, keep, 0, 8'h00);
        @(posedge core_clk);
        spa <= 1'b1;
        nv_op(1'b0, a, 8'hC3, 0, 8'h00);
        @(posedge core_clk);
        spa <= 1'b0;
        nv_op(1'b1, a, keep, 0, 8'h00);
        $display("refusals done");
        @(posedge core_clk);
        gie <= 1'b1;
        acc(1'b1, `NVAC_OFS_CONTROL, 8'h08, 1'b0);
        repeat (2) @(negedge core_clk);
        check({7'h00, ready_irq}, 8'h01);
        nv_op(1'b0, a, 8'h3C, 0, 8'h08);
        acc(1'b1, `NVAC_OFS_ADDR_LOW, 8'h00, 1'b0);
        acc(1'b0, `NVAC_OFS_ADDR_LOW, a[7:0], 1'b1);
        check({7'h00, ready_irq}, 8'h00);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        wait_idle();
        nv_op(1'b1, a, 8'h3C, 0, 8'h00);
        $display("interrupt and reset done");
        close_out();
    end
endmodule : nvac_ctrl_test
`default_nettype wire
